/* File: rtl/usb_irq_flags.sv */
// global event flags, enables and interrupt of the usb otg core
// assumes event pulses and status come from core logic on clk;
// role and line-idle arrive from pins and are synchronised here
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module usb_irq_flags #(
  parameter int unsigned IDLE_CYC = usb_irq_pkg::IDLE_CYC_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire usb_irq_pkg::bus_req_t   req,
  output logic [31:0]                  rdata,
  input  wire usb_irq_pkg::usb_evt_t   evt,
  input  wire usb_irq_pkg::core_stat_t stat,
  input  wire logic [31:0]             otg_flags,
  input  wire logic                    host_mode_pin,
  input  wire logic                    bus_idle_pin,
  output logic                         out_nak_req,
  output logic                         in_nak_req,
  output logic                         suspended,
  output logic                         irq
);
  import usb_irq_pkg::*;

  logic [1:0]  host_sync_reg;
  logic [1:0]  idle_sync_reg;
  logic [1:0]  thr_reg;
  logic        empty_lvl_reg;
  logic        out_nak_reg;
  logic        in_nak_reg;
  logic [31:0] enable_reg;
  logic [31:0] sticky_reg;
  logic [31:0] rdata_reg;
  logic [19:0] idle_cnt_reg;
  logic        eopf_done_reg;
  susp_state_t state_reg;
  susp_state_t state_next;
  logic        host_q;
  logic        dev_q;
  logic        idle_q;
  logic        dev_only;
  logic        fault;
  logic        wr_ok;
  logic        idle_hit;
  logic [13:0] eopf_thr;
  logic        eopf_hit;
  logic        np_empty;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] level_vec;
  logic [31:0] flags;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_sync_reg <= 2'h0;
      idle_sync_reg <= 2'h0;
    end
    else
    begin
      host_sync_reg <= {host_sync_reg[0], host_mode_pin};
      idle_sync_reg <= {idle_sync_reg[0], bus_idle_pin};
    end
  end

  assign host_q = host_sync_reg[1];
  assign dev_q  = !host_sync_reg[1];
  assign idle_q = idle_sync_reg[1];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // device-only registers touched in host mode are dropped
  assign dev_only = (req.addr == DEV_CFG_OFS) || (req.addr == DEV_CTL_OFS);
  assign fault    = (req.wr || req.rd) && dev_only && host_q;
  assign wr_ok    = req.wr && !fault;

  // configuration registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      thr_reg       <= THR_RST;
      empty_lvl_reg <= 1'b0;
      enable_reg    <= ENABLE_RST;
    end
    else if (wr_ok)
    begin
      if (req.addr == DEV_CFG_OFS)
        thr_reg <= req.wdata[1:0];
      if (req.addr == BUS_CFG_OFS)
        empty_lvl_reg <= req.wdata[EMPTY_LVL_BIT];
      if (req.addr == ENABLE_OFS)
        enable_reg <= req.wdata & IMPL_MASK;
    end
  end

  // global nak requests; a set in the same write beats a clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_nak_reg <= 1'b0;
      in_nak_reg  <= 1'b0;
    end
    else if (wr_ok && req.addr == DEV_CTL_OFS)
    begin
      if (req.wdata[SET_OUT_NAK_BIT])
        out_nak_reg <= 1'b1;
      else if (req.wdata[CLR_OUT_NAK_BIT])
        out_nak_reg <= 1'b0;
      if (req.wdata[SET_IN_NAK_BIT])
        in_nak_reg <= 1'b1;
      else if (req.wdata[CLR_IN_NAK_BIT])
        in_nak_reg <= 1'b0;
    end
  end

  assign out_nak_req = out_nak_reg;
  assign in_nak_req  = in_nak_reg;

  // ----------------------------------------
  // frame end detection
  // ----------------------------------------
  always_comb
  begin
    case (thr_reg)
      2'h0:    eopf_thr = EOPF_THR0;
      2'h1:    eopf_thr = EOPF_THR1;
      2'h2:    eopf_thr = EOPF_THR2;
      default: eopf_thr = EOPF_THR3;
    endcase
  end

  // one hit per frame; a new sof re-arms it
  assign eopf_hit = dev_q && !eopf_done_reg && (stat.frame_time >= eopf_thr);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      eopf_done_reg <= 1'b0;
    else if (evt.sof_rx)
      eopf_done_reg <= 1'b0;
    else if (eopf_hit)
      eopf_done_reg <= 1'b1;
  end

  // ----------------------------------------
  // idle timer and suspend state
  // ----------------------------------------
  assign idle_hit = (idle_cnt_reg == 20'(IDLE_CYC - 1));

  // counter holds once the early point is reached
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idle_cnt_reg <= 20'h0;
    else if (!idle_q || host_q)
      idle_cnt_reg <= 20'h0;
    else if (state_reg == ST_ACTIVE && !idle_hit)
      idle_cnt_reg <= idle_cnt_reg + 20'h1;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_ACTIVE:
        if (idle_q && dev_q && idle_hit)
          state_next = ST_EARLY;
      ST_EARLY:
        state_next = ST_SUSP;
      ST_SUSP:
        state_next = ST_SUSP;
      default:
        state_next = ST_ACTIVE;
    endcase
    // bus activity or host role leaves suspend at once
    if (!idle_q || host_q)
      state_next = ST_ACTIVE;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= ST_ACTIVE;
    else
      state_reg <= state_next;
  end

  assign suspended = (state_reg == ST_SUSP);

  // ----------------------------------------
  // event set and clear vectors
  // ----------------------------------------
  // events set flags regardless of enables
  always_comb
  begin
    set_vec            = 32'h0;
    set_vec[EOPF_BIT]  = eopf_hit;
    set_vec[ISOD_BIT]  = dev_q && evt.iso_out_rx && evt.rx_no_room;
    set_vec[ENUM_BIT]  = dev_q && evt.enum_done;
    set_vec[BRST_BIT]  = dev_q && evt.bus_reset;
    set_vec[SUSP_BIT]  = (state_reg == ST_EARLY);
    set_vec[ESUSP_BIT] = (state_reg == ST_ACTIVE) && state_next == ST_EARLY;
    set_vec[SOF_BIT]   = host_q ? evt.sof_tx : evt.sof_rx;
    set_vec[MFLT_BIT]  = fault;
  end

  // write one to the flags or to the clear register
  always_comb
  begin
    clr_vec = 32'h0;
    if (wr_ok && (req.addr == FLAGS_OFS || req.addr == CLEAR_OFS))
      clr_vec = req.wdata & STICKY_MASK;
  end

  // sticky flags, one per bit; set beats clear
  for (genvar i = 0; i < 32; i++)
  begin : g_sticky
    if (STICKY_MASK[i])
    begin : g_on
      logic flag_reg;
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          flag_reg <= 1'b0;
        else if (set_vec[i])
          flag_reg <= 1'b1;
        else if (clr_vec[i])
          flag_reg <= 1'b0;
      end
      assign sticky_reg[i] = flag_reg;
    end
    else
    begin : g_off
      assign sticky_reg[i] = 1'b0;
    end
  end

  // ----------------------------------------
  // level flags and read-back
  // ----------------------------------------
  assign np_empty = empty_lvl_reg ? (stat.np_tx_free == NP_TX_DEPTH)
                                  : (stat.np_tx_free >= NP_TX_HALF);

  always_comb
  begin
    level_vec           = 32'h0;
    level_vec[ONAK_BIT] = out_nak_reg && stat.out_nak_ack;
    level_vec[INAK_BIT] = in_nak_reg && stat.in_nak_ack;
    level_vec[NPTX_BIT] = host_q && np_empty;
    level_vec[RXNE_BIT] = (stat.rx_entries != 8'h0);
    level_vec[OTG_BIT]  = |otg_flags;
    level_vec[ROLE_BIT] = host_q;
  end

  assign flags = sticky_reg | level_vec;

  // only enabled flags reach the line
  assign irq = |(flags & enable_reg);

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_reg <= 32'h0;
    else if (req.rd && !fault)
    begin
      case (req.addr)
        DEV_CFG_OFS: rdata_reg <= {30'h0, thr_reg};
        DEV_CTL_OFS: rdata_reg <= {29'h0, out_nak_reg, 1'b0, in_nak_reg};
        BUS_CFG_OFS: rdata_reg <= {31'h0, empty_lvl_reg};
        FLAGS_OFS:   rdata_reg <= flags;
        ENABLE_OFS:  rdata_reg <= enable_reg;
        default:     rdata_reg <= 32'h0;
      endcase
    end
    else
      rdata_reg <= 32'h0;
  end

  assign rdata = rdata_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_frame_end: assert property (
    eopf_hit |=> sticky_reg[EOPF_BIT] && eopf_done_reg)
    else $error("frame end flag missing");

  a_iso_drop: assert property (
    dev_q && evt.iso_out_rx && evt.rx_no_room |=> sticky_reg[ISOD_BIT])
    else $error("iso drop flag missing");

  a_enum_done: assert property (
    dev_q && evt.enum_done |=> sticky_reg[ENUM_BIT])
    else $error("enum flag missing");

  a_bus_reset: assert property (
    dev_q && evt.bus_reset |=> sticky_reg[BRST_BIT])
    else $error("bus reset flag missing");

  a_suspend_entry: assert property (
    state_reg == ST_EARLY && idle_q && dev_q
      |=> suspended && sticky_reg[SUSP_BIT])
    else $error("suspend not entered");

  a_early_susp: assert property (
    $rose(state_reg == ST_EARLY) |-> sticky_reg[ESUSP_BIT] && idle_hit)
    else $error("early suspend wrong");

  a_sof_clear: assert property (
    wr_ok && req.addr == FLAGS_OFS && req.wdata[SOF_BIT]
      && !set_vec[SOF_BIT] |=> !sticky_reg[SOF_BIT])
    else $error("sof flag not cleared");

  a_otg_sum: assert property (
    req.rd && req.addr == FLAGS_OFS |=> rdata[OTG_BIT] == $past(|otg_flags))
    else $error("otg summary wrong");

  a_fault_drop: assert property (
    fault && req.wr |=> sticky_reg[MFLT_BIT] && $stable(thr_reg))
    else $error("mode fault wrong");

  a_role_read: assert property (
    req.rd && req.addr == FLAGS_OFS |=> rdata[ROLE_BIT] == $past(host_q))
    else $error("role bit wrong");

  a_irq_masked: assert property (
    enable_reg == 32'h0 |-> !irq)
    else $error("irq while all disabled");

  a_irq_raise: assert property (
    $rose(sticky_reg[SOF_BIT]) && enable_reg[SOF_BIT] |-> irq)
    else $error("irq missing");

  c_irq_rise:   cover property ($rose(irq));
  c_suspended:  cover property ($rose(suspended));
  c_mode_fault: cover property (fault && req.wr);
  c_sof_clear:  cover property (clr_vec[SOF_BIT] && sticky_reg[SOF_BIT]);

endmodule

`default_nettype wire

/* File: rtl/usb_irq_pkg.sv */
// constants and carriers of the global event flag block
// assumes one 200 MHz system clock shared by core and registers
package usb_irq_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] DEV_CFG_OFS  = 8'h00;
  localparam logic [7:0] DEV_CTL_OFS  = 8'h04;
  localparam logic [7:0] BUS_CFG_OFS  = 8'h08;
  localparam logic [7:0] FLAGS_OFS    = 8'h14;
  localparam logic [7:0] ENABLE_OFS   = 8'h18;
  localparam logic [7:0] CLEAR_OFS    = 8'h1c;

  // ----------------------------------------
  // flag bit positions
  // ----------------------------------------
  localparam int EOPF_BIT  = 15;
  localparam int ISOD_BIT  = 14;
  localparam int ENUM_BIT  = 13;
  localparam int BRST_BIT  = 12;
  localparam int SUSP_BIT  = 11;
  localparam int ESUSP_BIT = 10;
  localparam int ONAK_BIT  = 7;
  localparam int INAK_BIT  = 6;
  localparam int NPTX_BIT  = 5;
  localparam int RXNE_BIT  = 4;
  localparam int SOF_BIT   = 3;
  localparam int OTG_BIT   = 2;
  localparam int MFLT_BIT  = 1;
  localparam int ROLE_BIT  = 0;

  // control field positions
  localparam int SET_IN_NAK_BIT  = 0;
  localparam int CLR_IN_NAK_BIT  = 1;
  localparam int SET_OUT_NAK_BIT = 2;
  localparam int CLR_OUT_NAK_BIT = 3;
  localparam int EMPTY_LVL_BIT   = 0;

  // masks and reset values
  localparam logic [31:0] STICKY_MASK = 32'h0000_fc0a;
  localparam logic [31:0] IMPL_MASK   = 32'h0000_fcff;
  localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
  localparam logic [1:0]  THR_RST     = 2'h0;

  // frame-end points in bit times within a frame
  localparam logic [13:0] EOPF_THR0 = 14'h2580;
  localparam logic [13:0] EOPF_THR1 = 14'h27d8;
  localparam logic [13:0] EOPF_THR2 = 14'h2a30;
  localparam logic [13:0] EOPF_THR3 = 14'h2c88;

  // non-periodic tx fifo depth in words
  localparam logic [7:0] NP_TX_DEPTH = 8'h10;
  localparam logic [7:0] NP_TX_HALF  = 8'h08;

  // bus idle time before suspend
  localparam int CLK_MHZ      = 200;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYC_DEF = IDLE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_EARLY  = 2'b01,
    ST_SUSP   = 2'b11
  } susp_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic sof_tx;
    logic sof_rx;
    logic iso_out_rx;
    logic rx_no_room;
    logic enum_done;
    logic bus_reset;
  } usb_evt_t;

  typedef struct packed {
    logic [13:0] frame_time;
    logic [7:0]  np_tx_free;
    logic [7:0]  rx_entries;
    logic        out_nak_ack;
    logic        in_nak_ack;
  } core_stat_t;

endpackage

/* File: verif/testbench.sv */
// self-checking bench of the global event flag block
// assumes the bus model below and a short idle count for suspend
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import usb_irq_pkg::*;
  logic        clk, rst_b, go, full, host, idle, irq, susp, onak, inak;
  logic [2:0]  kind;
  logic [31:0] rdata, otg, d;
  bus_req_t    req;
  usb_evt_t    evt;
  core_stat_t  stat;
  int          n_mismatch, comparisons;
  int          bits [5] = '{SOF_BIT, SOF_BIT, ISOD_BIT, ENUM_BIT, BRST_BIT};

  usb_irq_flags #(.IDLE_CYC(20)) usb_irq_flags_inst (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .evt(evt), .stat(stat),
    .otg_flags(otg), .host_mode_pin(host), .bus_idle_pin(idle), .out_nak_req(onak),
    .in_nak_req(inak), .suspended(susp), .irq(irq));
  usb_bus_model usb_bus_model_inst (
    .clk(clk), .rst_b(rst_b), .go(go), .kind(kind), .full(full), .evt(evt));

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bus cycles: strobes last one cycle, data stands the cycle after a read
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    // taken before this edge's updates land, so the caller stays on the edge
    @(posedge clk);
    v = rdata;
  endtask

  task automatic bit_is(input string nm, input int b, input logic e);
    rd(FLAGS_OFS, d);
    check(nm, {31'h0, d[b]}, {31'h0, e});
  endtask

  task automatic pulse(input logic [2:0] k);
    @(posedge clk);
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #20000;
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    rst_b = 1'b0;
    {go, kind, full, host, idle, otg, req, stat} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(ENABLE_OFS, d);
    check("enable_reset", d, ENABLE_RST);
    wr(ENABLE_OFS, 32'hffff_ffff);
    rd(ENABLE_OFS, d);
    check("enable_mask", d, IMPL_MASK);
    wr(ENABLE_OFS, 32'h0);
    rd(8'h40, d);
    check("unmapped", d, 32'h0);
    rd(CLEAR_OFS, d);
    check("clear_reads", d, 32'h0);
    // masked device events still latch; write one clears them
    full <= 1'b1;
    for (int i = 1; i < 5; i++)
    begin
      pulse(i[2:0]);
      bit_is("event_set", bits[i], 1'b1);
      check("irq_masked", {31'h0, irq}, 32'h0);
      wr(FLAGS_OFS, 32'h1 << bits[i]);
      bit_is("event_clr", bits[i], 1'b0);
    end
    full <= 1'b0;
    // host-side sof and an iso packet with room leave their flags alone
    pulse(3'h0);
    bit_is("sof_tx_dev", SOF_BIT, 1'b0);
    pulse(3'h2);
    bit_is("iso_room", ISOD_BIT, 1'b0);
    // enabled event raises the line until cleared
    wr(ENABLE_OFS, 32'h1 << ENUM_BIT);
    pulse(3'h3);
    bit_is("enum_set", ENUM_BIT, 1'b1);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(CLEAR_OFS, 32'h1 << ENUM_BIT);
    bit_is("enum_clr", ENUM_BIT, 1'b0);
    check("irq_off", {31'h0, irq}, 32'h0);
    // level flags follow their sources
    stat.rx_entries <= 8'h01;
    bit_is("rx_ne", RXNE_BIT, 1'b1);
    stat.rx_entries <= 8'h00;
    bit_is("rx_empty", RXNE_BIT, 1'b0);
    otg <= 32'h0000_0004;
    bit_is("otg_set", OTG_BIT, 1'b1);
    otg <= 32'h0;
    bit_is("otg_clr", OTG_BIT, 1'b0);
    // nak acknowledged early must not show before the request
    stat.out_nak_ack <= 1'b1;
    stat.in_nak_ack <= 1'b1;
    bit_is("onak_early", ONAK_BIT, 1'b0);
    wr(DEV_CTL_OFS, 32'h5);
    bit_is("onak_eff", ONAK_BIT, 1'b1);
    bit_is("inak_eff", INAK_BIT, 1'b1);
    check("out_nak_req", {31'h0, onak}, 32'h1);
    check("in_nak_req", {31'h0, inak}, 32'h1);
    wr(DEV_CTL_OFS, 32'ha);
    bit_is("onak_off", ONAK_BIT, 1'b0);
    check("out_nak_off", {31'h0, onak}, 32'h0);
    check("in_nak_off", {31'h0, inak}, 32'h0);
    // frame end at threshold 1, at the threshold 0 point below it and at its own point
    wr(DEV_CFG_OFS, 32'h1);
    stat.frame_time <= EOPF_THR0;
    bit_is("eopf_below", EOPF_BIT, 1'b0);
    stat.frame_time <= EOPF_THR1;
    bit_is("eopf_at", EOPF_BIT, 1'b1);
    // idle bus: nothing early, both suspend flags once the count runs out
    idle <= 1'b1;
    repeat (8) @(posedge clk);
    bit_is("esusp_early", ESUSP_BIT, 1'b0);
    repeat (20) @(posedge clk);
    bit_is("esusp", ESUSP_BIT, 1'b1);
    bit_is("susp", SUSP_BIT, 1'b1);
    check("suspended", {31'h0, susp}, 32'h1);
    idle <= 1'b0;
    // host role: role bit, tx empty level, sof, wrong-mode access
    host <= 1'b1;
    stat.np_tx_free <= NP_TX_HALF;
    repeat (4) @(posedge clk);
    bit_is("role_host", ROLE_BIT, 1'b1);
    bit_is("nptx_half", NPTX_BIT, 1'b1);
    wr(BUS_CFG_OFS, 32'h1);
    bit_is("nptx_full_lvl", NPTX_BIT, 1'b0);
    stat.np_tx_free <= NP_TX_DEPTH;
    bit_is("nptx_empty", NPTX_BIT, 1'b1);
    pulse(3'h3);
    bit_is("enum_host", ENUM_BIT, 1'b0);
    wr(ENABLE_OFS, 32'h1 << SOF_BIT);
    pulse(3'h0);
    bit_is("sof_host", SOF_BIT, 1'b1);
    check("irq_sof", {31'h0, irq}, 32'h1);
    wr(DEV_CFG_OFS, 32'h3);
    bit_is("mode_fault", MFLT_BIT, 1'b1);
    rd(DEV_CFG_OFS, d);
    check("fault_read", d, 32'h0);
    host <= 1'b0;
    repeat (4) @(posedge clk);
    bit_is("role_dev", ROLE_BIT, 1'b0);
    rd(DEV_CFG_OFS, d);
    check("cfg_kept", d & 32'h3, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire

/* File: verif/usb_bus_model.sv */
// far-side bus model: turns bench commands into one-cycle core events
// assumes commands change by non-blocking assignment after a rising edge
`timescale 1ns/10ps
`default_nettype none
module usb_bus_model (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  go,
  input  wire logic [2:0]            kind,
  input  wire logic                  full,
  output var  usb_irq_pkg::usb_evt_t evt
);
  import usb_irq_pkg::*;

  // ----------------------------------------
  // event pulses
  // ----------------------------------------
  // one cycle per event; a stretched pulse would hide a double count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evt <= '0;
    else
    begin
      evt <= '0;
      evt.rx_no_room <= full;
      if (go)
        case (kind)
          3'h0: evt.sof_tx <= 1'b1;
          3'h1: evt.sof_rx <= 1'b1;
          3'h2: evt.iso_out_rx <= 1'b1;
          3'h3: evt.enum_done <= 1'b1;
          default: evt.bus_reset <= 1'b1;
        endcase
    end
  end
endmodule
`default_nettype wire
